// File: logic/srw_defines.svh
/*
  Constants for the capture window detector and automatic delay calibration:
  register byte offsets, field positions, reset values and timing counts.
  Assumes it is included by bare name from the package and the testbench.
*/
`ifndef SRW_DEFINES_SVH
`define SRW_DEFINES_SVH

// ----------------------------------------------------------------------------
// register offsets (8-bit address, 8-bit data)
// ----------------------------------------------------------------------------
`define SRW_ADDR_CLK_CTRL 8'h29
`define SRW_ADDR_FLAGS_LO 8'h2c
`define SRW_ADDR_FLAGS_MID 8'h2d
`define SRW_ADDR_FLAGS_HI 8'h2e
`define SRW_ADDR_CAL_EN 8'h30
`define SRW_ADDR_CAL_CFG 8'h31
`define SRW_ADDR_CAL_STAT 8'h32
`define SRW_ADDR_RES_COARSE 8'h33
`define SRW_ADDR_CLOCK_INVERT_DELAY 8'h35
`define SRW_ADDR_COARSE_DELAY_CODE 8'h36
`define SRW_ADDR_FINE_DELAY_CODE 8'h37

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SRW_SEL_MSB 3
`define SRW_FINE_BIT 4
`define SRW_STAT_DONE 0
`define SRW_STAT_VALID 1
`define SRW_STAT_MISS 2
`define SRW_STAT_INV 3

// ----------------------------------------------------------------------------
// sizes, reset values, timing
// ----------------------------------------------------------------------------
`define SRW_TAPS 24
`define SRW_FLAGS_RST 24'h80_0001
`define SRW_EDGES_VALID 2'h3
`define SRW_SETTLE_BASE 12'h010
`define SRW_COARSE_MAX 8'hff

`endif

// File: logic/srw_pkg.sv
/*
  Types shared by the window detector top and the calibration engine.
  Assumes srw_defines.svh is on the include path.
*/
`include "srw_defines.svh"

package srw_pkg;

  typedef enum logic [1:0] {
    SRW_CAL_IDLE,
    SRW_CAL_SETTLE,
    SRW_CAL_FINISH
  } srw_cal_state_t;

  typedef struct packed {
    srw_cal_state_t state;
    logic [11:0] wait_cnt;
    logic inv;
    logic [7:0] coarse;
    logic found;
    logic best_inv;
    logic [7:0] best_coarse;
    logic done;
    logic miss;
  } srw_cal_reg_t;

  typedef struct packed {
    logic [`SRW_TAPS-1:0] tap_s1;
    logic [`SRW_TAPS-1:0] tap_s2;
    logic [`SRW_TAPS-1:0] snap;
    logic [`SRW_TAPS-1:0] flags;
    logic sr_s1;
    logic sr_s2;
    logic sr_s3;
    logic pd_s1;
    logic pd_s2;
    logic [1:0] edges;
    logic [3:0] tap_sel;
    logic step_fine;
    logic cal_en;
    logic cal_start;
    logic [2:0] settle_sel;
    logic use_manual;
    logic capture;
    logic clock_invert_delay;
    logic [7:0] coarse_delay_code;
    logic [7:0] fine_delay_code;
    logic out_inv;
    logic [7:0] out_coarse;
    logic [7:0] out_fine;
    logic [7:0] rdata;
  } srw_top_state_t;

endpackage : srw_pkg

// File: logic/srw_cal_if.sv
/*
  Link between the register block and the calibration engine.
  Assumes both ends run on the same device clock.
*/
`timescale 1ns/1ps

interface srw_cal_if;
  logic start;
  logic enable;
  logic [2:0] settle_sel;
  logic phase;
  logic busy;
  logic done;
  logic miss;
  logic try_inv;
  logic [7:0] try_coarse;
  logic res_inv;
  logic [7:0] res_coarse;

  modport ctl (
    output start, enable, settle_sel, phase,
    input busy, done, miss, try_inv, try_coarse, res_inv, res_coarse
  );
  modport eng (
    input start, enable, settle_sel, phase,
    output busy, done, miss, try_inv, try_coarse, res_inv, res_coarse
  );
endinterface : srw_cal_if

// File: logic/srw_autocal.sv
/*
  Calibration engine: walks coarse delay codes with both clock polarities and
  keeps the smallest coarse code at which the falling edge meets SYSREF.
  Assumes the phase input is already synchronised to i_mclk.
*/
`timescale 1ns/1ps

module srw_autocal import srw_pkg::*; (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // engine side
  srw_cal_if.eng cal
);

  srw_cal_reg_t r;
  srw_cal_reg_t next_r;
  logic [11:0] settle_load;

  // --------------------------------------------------------------------------
  // search sequence
  // --------------------------------------------------------------------------
  always_comb begin
    settle_load = 12'(`SRW_SETTLE_BASE << cal.settle_sel);
    next_r = r;
    if (!i_rst_n) begin
      next_r = '0;
    end else if (!cal.enable) begin
      next_r.state = SRW_CAL_IDLE;
      next_r.done = 1'b0;
    end else if (cal.start) begin
      next_r.state = SRW_CAL_SETTLE;
      next_r.inv = 1'b0;
      next_r.coarse = 8'h00;
      next_r.wait_cnt = settle_load;
      next_r.found = 1'b0;
      // a search without a hit must not report the previous result
      next_r.best_inv = 1'b0;
      next_r.best_coarse = 8'h00;
      next_r.done = 1'b0;
      next_r.miss = 1'b0;
    end else begin
      case (r.state)
        SRW_CAL_IDLE: begin
          next_r.state = SRW_CAL_IDLE;
        end
        SRW_CAL_SETTLE: begin
          // let the analog delay settle before trusting the phase detector
          if (r.wait_cnt != 12'h000) begin
            next_r.wait_cnt = r.wait_cnt - 12'h001;
          end else if (cal.phase || r.coarse == `SRW_COARSE_MAX) begin
            if (cal.phase && (!r.found || r.coarse < r.best_coarse)) begin
              next_r.found = 1'b1;
              next_r.best_inv = r.inv;
              next_r.best_coarse = r.coarse;
            end
            if (!r.inv) begin
              next_r.inv = 1'b1;
              next_r.coarse = 8'h00;
              next_r.wait_cnt = settle_load;
            end else begin
              next_r.state = SRW_CAL_FINISH;
            end
          end else begin
            next_r.coarse = r.coarse + 8'h01;
            next_r.wait_cnt = settle_load;
          end
        end
        SRW_CAL_FINISH: begin
          next_r.done = 1'b1;
          next_r.miss = !r.found;
          next_r.state = SRW_CAL_IDLE;
        end
        default: begin
          next_r.state = SRW_CAL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    r <= next_r;
  end

  assign cal.busy = (r.state != SRW_CAL_IDLE);
  assign cal.done = r.done;
  assign cal.miss = r.miss;
  assign cal.try_inv = r.inv;
  assign cal.try_coarse = r.coarse;
  assign cal.res_inv = r.best_inv;
  assign cal.res_coarse = r.best_coarse;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  done_not_busy_a: assert property (cal.busy |-> !cal.done)
    else $error("done raised while search still running");
  coarse_step_a: assert property (
    (r.state == SRW_CAL_SETTLE && r.wait_cnt == 12'h000 && !cal.phase && r.coarse != `SRW_COARSE_MAX
     && cal.enable && !cal.start) |=> r.coarse == $past(r.coarse) + 8'h01)
    else $error("coarse code did not advance by one");
  result_hold_a: assert property (
    (cal.done && cal.enable && !cal.start) |=> $stable(cal.res_coarse) && $stable(cal.res_inv))
    else $error("calibrated delay changed after completion");
  best_smallest_a: assert property (
    (r.state == SRW_CAL_SETTLE && r.wait_cnt == 12'h000 && cal.phase && r.found
     && cal.enable && !cal.start) |=> r.best_coarse <= $past(r.coarse))
    else $error("kept a larger coarse code than found");
  cal_done_c: cover property (!cal.done ##1 cal.done && !cal.miss);
  cal_inv_win_c: cover property ($rose(cal.done) && cal.res_inv);

endmodule : srw_autocal

// File: logic/srw_top.sv
/*
  SYSREF capture window detector with tap select, plus register block and
  delay selection around the automatic calibration engine.
  Assumes tap samples, SYSREF and the phase detector arrive unsynchronised
  from the analog delay line; the delay outputs drive that delay line.
*/
// Summary of operation
// - measure SYSREF position into per-tap flag vector
// - flags invalid before three SYSREF rising edges
// - flag one marks violation, zero usable tap
// - lowest and highest flags always read one
// - tap select index picks capture clock tap
// - 24 flags reported, only 16 selectable
// - step bit: zero coarse, one fine spacing
// - enabled search steps delay until edges align
// - done flag raised when search completes
// - found delay readable in status (invert) and result coarse registers
// - calibrated delay kept applied afterwards
// - software may disable and override delay fields
// - search both polarities, keep smallest coarse
// - invert bit adds half-period, independent of codes
`timescale 1ns/1ps

module srw_top import srw_pkg::*; (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // analog delay line samples and SYSREF
  input wire logic [`SRW_TAPS-1:0] i_tap_sample,
  input wire logic i_sysref,
  input wire logic i_phase_aligned,
  // capture and delay control
  output logic o_sysref_capture,
  output logic o_tap_step_fine,
  output logic o_clock_invert_delay,
  output logic [7:0] o_coarse_delay_code,
  output logic [7:0] o_fine_delay_code,
  output logic o_autocal_done
);

  srw_top_state_t s;
  srw_top_state_t next_s;
  srw_cal_if cal ();
  logic sr_rise;
  // a net, because each tap bit has its own continuous assignment
  wire logic [`SRW_TAPS-1:0] raw_flags;
  logic wr_clk;
  logic wr_cal_en;
  logic wr_tad;

  // --------------------------------------------------------------------------
  // per-tap violation detection
  // --------------------------------------------------------------------------
  // a tap is suspect when its sample moved between two SYSREF edges or when
  // its neighbour disagrees, i.e. the edge falls next to that tap
  assign raw_flags[0] = 1'b1;
  assign raw_flags[`SRW_TAPS-1] = 1'b1;
  genvar g;
  generate
    for (g = 1; g < `SRW_TAPS - 1; g++) begin : g_flag
      assign raw_flags[g] = (s.tap_s2[g] ^ s.snap[g]) | (s.tap_s2[g] ^ s.tap_s2[g+1]);
    end
  endgenerate

  assign sr_rise = s.sr_s2 & ~s.sr_s3;
  assign wr_clk = i_wr && i_addr == `SRW_ADDR_CLK_CTRL;
  assign wr_cal_en = i_wr && i_addr == `SRW_ADDR_CAL_EN;
  assign wr_tad = i_wr && (i_addr == `SRW_ADDR_CLOCK_INVERT_DELAY || i_addr == `SRW_ADDR_COARSE_DELAY_CODE
    || i_addr == `SRW_ADDR_FINE_DELAY_CODE);

  // --------------------------------------------------------------------------
  // calibration engine
  // --------------------------------------------------------------------------
  assign cal.start = s.cal_start;
  assign cal.enable = s.cal_en;
  assign cal.settle_sel = s.settle_sel;
  assign cal.phase = s.pd_s2;

  srw_autocal u_autocal (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .cal(cal)
  );

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_s = s;
    // pin synchronisers: the first stage feeds only the second
    next_s.tap_s1 = i_tap_sample;
    next_s.tap_s2 = s.tap_s1;
    next_s.sr_s1 = i_sysref;
    next_s.sr_s2 = s.sr_s1;
    next_s.sr_s3 = s.sr_s2;
    next_s.pd_s1 = i_phase_aligned;
    next_s.pd_s2 = s.pd_s1;
    next_s.cal_start = 1'b0;
    next_s.rdata = 8'h00;

    if (sr_rise) begin
      next_s.snap = s.tap_s2;
      next_s.flags = raw_flags;
      if (s.edges != `SRW_EDGES_VALID) begin
        next_s.edges = s.edges + 2'h1;
      end
    end

    // only the low 16 taps can be chosen; the index is four bits wide
    next_s.capture = s.tap_s2[s.tap_sel];

    if (wr_clk) begin
      next_s.tap_sel = i_wdata[`SRW_SEL_MSB:0];
      next_s.step_fine = i_wdata[`SRW_FINE_BIT];
    end
    if (i_wr && i_addr == `SRW_ADDR_CAL_CFG) begin
      next_s.settle_sel = i_wdata[2:0];
    end
    if (wr_cal_en) begin
      next_s.cal_en = i_wdata[0];
      // writing one, even when already set, relaunches the search
      next_s.cal_start = i_wdata[0];
      if (i_wdata[0]) begin
        next_s.use_manual = 1'b0;
      end
    end
    if (i_wr && i_addr == `SRW_ADDR_CLOCK_INVERT_DELAY) begin
      next_s.clock_invert_delay = i_wdata[0];
    end
    if (i_wr && i_addr == `SRW_ADDR_COARSE_DELAY_CODE) begin
      next_s.coarse_delay_code = i_wdata;
    end
    if (i_wr && i_addr == `SRW_ADDR_FINE_DELAY_CODE) begin
      next_s.fine_delay_code = i_wdata;
    end
    // an override write takes over from the calibrated value
    if (wr_tad) begin
      next_s.use_manual = 1'b1;
    end

    // delay actually driven into the clock path; invert is independent
    if (cal.busy) begin
      next_s.out_inv = cal.try_inv;
      next_s.out_coarse = cal.try_coarse;
      next_s.out_fine = 8'h00;
    end else if (s.use_manual) begin
      next_s.out_inv = s.clock_invert_delay;
      next_s.out_coarse = s.coarse_delay_code;
      next_s.out_fine = s.fine_delay_code;
    end else begin
      next_s.out_inv = cal.res_inv;
      next_s.out_coarse = cal.res_coarse;
      next_s.out_fine = 8'h00;
    end

    if (i_rd) begin
      case (i_addr)
        `SRW_ADDR_CLK_CTRL: next_s.rdata = {3'h0, s.step_fine, s.tap_sel};
        `SRW_ADDR_FLAGS_LO: next_s.rdata = s.flags[7:0];
        `SRW_ADDR_FLAGS_MID: next_s.rdata = s.flags[15:8];
        `SRW_ADDR_FLAGS_HI: next_s.rdata = s.flags[23:16];
        `SRW_ADDR_CAL_EN: next_s.rdata = {7'h00, s.cal_en};
        `SRW_ADDR_CAL_CFG: next_s.rdata = {5'h00, s.settle_sel};
        `SRW_ADDR_CAL_STAT: begin
          next_s.rdata = 8'h00;
          next_s.rdata[`SRW_STAT_DONE] = cal.done;
          next_s.rdata[`SRW_STAT_VALID] = (s.edges == `SRW_EDGES_VALID);
          next_s.rdata[`SRW_STAT_MISS] = cal.miss;
          next_s.rdata[`SRW_STAT_INV] = cal.res_inv;
        end
        `SRW_ADDR_RES_COARSE: next_s.rdata = cal.res_coarse;
        `SRW_ADDR_CLOCK_INVERT_DELAY: next_s.rdata = {7'h00, s.clock_invert_delay};
        `SRW_ADDR_COARSE_DELAY_CODE: next_s.rdata = s.coarse_delay_code;
        `SRW_ADDR_FINE_DELAY_CODE: next_s.rdata = s.fine_delay_code;
        default: next_s.rdata = 8'h00;
      endcase
    end

    if (!i_rst_n) begin
      next_s = '0;
      next_s.flags = `SRW_FLAGS_RST;
      next_s.use_manual = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    s <= next_s;
  end

  assign o_rdata = s.rdata;
  assign o_sysref_capture = s.capture;
  assign o_tap_step_fine = s.step_fine;
  assign o_clock_invert_delay = s.out_inv;
  assign o_coarse_delay_code = s.out_coarse;
  assign o_fine_delay_code = s.out_fine;
  assign o_autocal_done = cal.done;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  ends_pinned_a: assert property (s.flags[0] && s.flags[`SRW_TAPS-1])
    else $error("end flags not held at one");
  valid_after_edge_a: assert property ($rose(s.edges == `SRW_EDGES_VALID) |-> $past(sr_rise))
    else $error("flags valid without a SYSREF edge");
  flags_read_a: assert property ((i_rd && i_addr == `SRW_ADDR_FLAGS_LO) |=> o_rdata == $past(s.flags[7:0]))
    else $error("low flag byte read wrong");
  tap_capture_a: assert property (##1 o_sysref_capture == $past(s.tap_s2[s.tap_sel]))
    else $error("capture not from selected tap");
  sel_write_a: assert property (wr_clk |=> s.tap_sel == $past(i_wdata[3:0]))
    else $error("tap select not taken from write");
  step_write_a: assert property (wr_clk |=> o_tap_step_fine == $past(i_wdata[4]))
    else $error("step spacing bit not taken from write");
  manual_apply_a: assert property ((s.use_manual && !cal.busy) |=> o_coarse_delay_code == $past(s.coarse_delay_code))
    else $error("override coarse code not applied");
  done_clear_a: assert property ($fell(s.cal_en) |=> !o_autocal_done)
    else $error("done still set after disable");
  flags_valid_c: cover property ($rose(s.edges == `SRW_EDGES_VALID));
  override_c: cover property (wr_tad ##1 !cal.busy);
  restart_c: cover property (cal.busy && s.cal_start);

endmodule : srw_top

// File: dv/srw_source_model.sv
/*
  Behavioural clock source and delay line: periodic SYSREF, static tap
  samples and a phase detector that trips at a target coarse code.
  Assumes the bench makes the device clock and raises i_run to start SYSREF.
*/
`timescale 1ns/1ps

module srw_source_model #(
  parameter int PERIOD = 40
) (
  // clock and control from the bench
  input wire logic i_mclk,
  input wire logic i_run,
  input wire logic [23:0] i_tap_mask,
  input wire logic [8:0] i_target_plain,
  input wire logic [8:0] i_target_inv,
  // applied delay from the device
  input wire logic i_inv,
  input wire logic [7:0] i_coarse,
  // toward the device
  output logic o_sysref,
  output logic [23:0] o_tap_sample,
  output logic o_phase_aligned
);
  int cnt;

  initial begin
    cnt = 0;
    o_sysref = 1'b0;
    o_tap_sample = 24'h00_0000;
    o_phase_aligned = 1'b0;
  end

  always @(posedge i_mclk) begin
    cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    o_sysref <= i_run && (cnt < PERIOD / 2);
    o_tap_sample <= i_tap_mask;
    // a target above 8'hff never trips, which models a search with no hit
    o_phase_aligned <= i_inv ? ({1'b0, i_coarse} >= i_target_inv) : ({1'b0, i_coarse} >= i_target_plain);
  end
endmodule : srw_source_model

// File: dv/test_srw_top.sv
/*
  Bench for srw_top: register tasks, window flag, capture and calibration tests.
  Assumes srw_source_model stands in for the clock source and the delay line.
*/
`timescale 1ns/1ps
`include "srw_defines.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module test_srw_top import srw_pkg::*; ;
  localparam int PER = 40;
  logic i_mclk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, run = 1'b0, ei;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, ec, o_coarse_delay_code, o_fine_delay_code;
  logic [23:0] mask = 24'h00_0000, f, i_tap_sample;
  logic [8:0] tgt0 = 9'h100, tgt1 = 9'h100;
  logic i_sysref, i_phase_aligned, o_sysref_capture, o_tap_step_fine, o_clock_invert_delay, o_autocal_done;
  logic [23:0] pats [3] = '{24'h00_000f, 24'hff_f000, 24'h3c_a5c3};
  logic [8:0] t0s [4] = '{9'h100, 9'h005, 9'h00c, 9'h007};
  logic [8:0] t1s [4] = '{9'h100, 9'h009, 9'h003, 9'h007};
  int errors = 0, checked = 0;

  initial begin
    forever #12.5 i_mclk = ~i_mclk;
  end

  srw_top dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_tap_sample(i_tap_sample), .i_sysref(i_sysref),
    .i_phase_aligned(i_phase_aligned), .o_sysref_capture(o_sysref_capture), .o_tap_step_fine(o_tap_step_fine),
    .o_clock_invert_delay(o_clock_invert_delay), .o_coarse_delay_code(o_coarse_delay_code),
    .o_fine_delay_code(o_fine_delay_code), .o_autocal_done(o_autocal_done));

  srw_source_model #(.PERIOD(PER)) src_u (.i_mclk(i_mclk), .i_run(run), .i_tap_mask(mask),
    .i_target_plain(tgt0), .i_target_inv(tgt1), .i_inv(o_clock_invert_delay), .i_coarse(o_coarse_delay_code),
    .o_sysref(i_sysref), .o_tap_sample(i_tap_sample), .o_phase_aligned(i_phase_aligned));

  // --------------------------------------------------------------------------
  // register port tasks
  // --------------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
    `CHK(v, e)
  endtask : chk_rd

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : wait_cyc

  task automatic wait_done();
    for (int i = 0; i < 20000 && o_autocal_done !== 1'b1; i++) wait_cyc(1);
    if (o_autocal_done !== 1'b1) begin
      errors++;
      conclude();
    end
  endtask : wait_done

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  // edges 0 and 23 cannot be judged; elsewhere a step between neighbours is flagged
  function automatic logic [23:0] exp_flags(input logic [23:0] m);
    logic [23:0] r;
    r = 24'h80_0001;
    for (int i = 1; i < 23; i++) r[i] = m[i] ^ m[i + 1];
    return r;
  endfunction : exp_flags

  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    chk_rd(`SRW_ADDR_CAL_STAT, 8'h00);
    chk_rd(`SRW_ADDR_FLAGS_LO, 8'h01);
    chk_rd(`SRW_ADDR_FLAGS_HI, 8'h80);
    run <= 1'b1;
    wait_cyc(3 * PER + 10);
    chk_rd(`SRW_ADDR_CAL_STAT, 8'h02);
    wr(`SRW_ADDR_FLAGS_LO, 8'hfe);
    chk_rd(`SRW_ADDR_FLAGS_LO, 8'h01);
    chk_rd(8'h40, 8'h00);
    $display("test reset_and_validity done");
    for (int p = 0; p < 3; p++) begin
      mask <= pats[p];
      wait_cyc(3 * PER + 10);
      f = exp_flags(pats[p]);
      chk_rd(`SRW_ADDR_FLAGS_LO, f[7:0]);
      chk_rd(`SRW_ADDR_FLAGS_MID, f[15:8]);
      chk_rd(`SRW_ADDR_FLAGS_HI, f[23:16]);
      for (int s = 0; s < 16; s++) begin
        wr(`SRW_ADDR_CLK_CTRL, {3'h0, s[0], s[3:0]});
        wait_cyc(4);
        `CHK(o_sysref_capture, pats[p][s])
        `CHK(o_tap_step_fine, s[0])
      end
      chk_rd(`SRW_ADDR_CLK_CTRL, 8'h1f);
    end
    // flags of the last pattern mark taps 1 and 5, so software settles on tap 3
    wr(`SRW_ADDR_CLK_CTRL, 8'h03);
    wait_cyc(4);
    `CHK(o_sysref_capture, pats[2][3])
    $display("test window_and_capture done");
    wr(`SRW_ADDR_CLK_CTRL, 8'h00);
    wr(`SRW_ADDR_CAL_CFG, 8'h00);
    for (int c = 0; c < 4; c++) begin
      tgt0 <= t0s[c];
      tgt1 <= t1s[c];
      ei = t1s[c] < t0s[c];
      ec = ei ? t1s[c][7:0] : t0s[c][7:0];
      wr(`SRW_ADDR_CAL_EN, 8'h01);
      wait_cyc(3);
      `CHK(o_autocal_done, 1'b0)
      wait_done();
      // the delay outputs switch to the result one cycle after done rises
      wait_cyc(1);
      `CHK(o_clock_invert_delay, ei)
      `CHK(o_coarse_delay_code, ec)
      `CHK(o_fine_delay_code, 8'h00)
      chk_rd(`SRW_ADDR_CAL_STAT, {4'h0, ei, t0s[c][8] & t1s[c][8], 2'h3});
      chk_rd(`SRW_ADDR_RES_COARSE, ec);
    end
    $display("test calibration_search done");
    wr(`SRW_ADDR_CAL_EN, 8'h00);
    wait_cyc(3);
    `CHK(o_autocal_done, 1'b0)
    `CHK(o_coarse_delay_code, 8'h07)
    wr(`SRW_ADDR_CLOCK_INVERT_DELAY, 8'h01);
    wr(`SRW_ADDR_COARSE_DELAY_CODE, 8'h22);
    wr(`SRW_ADDR_FINE_DELAY_CODE, 8'h44);
    wait_cyc(3);
    `CHK(o_clock_invert_delay, 1'b1)
    `CHK(o_coarse_delay_code, 8'h22)
    `CHK(o_fine_delay_code, 8'h44)
    chk_rd(`SRW_ADDR_COARSE_DELAY_CODE, 8'h22);
    $display("test manual_override done");
    conclude();
  end
endmodule : test_srw_top
